/* File: verilog/mis_map.svh */
// Constants for the instruction subset executor: bus offsets, fields, opcodes, counts.
// Included by the package user files; definitions only.
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH
`define MIS_OFF_CTRL     8'h00
`define MIS_OFF_INSTR    8'h04
`define MIS_OFF_ACC      8'h08
`define MIS_OFF_BANK     8'h0C
`define MIS_OFF_PTR2     8'h10
`define MIS_OFF_STATUS   8'h14
`define MIS_OFF_MEMADDR  8'h18
`define MIS_OFF_MEMDATA  8'h1C
`define MIS_CTRL_EXT     0
`define MIS_CTRL_NEXT2W  1
`define MIS_ST_C         0
`define MIS_ST_DC        1
`define MIS_ST_Z         2
`define MIS_ST_OV        3
`define MIS_ST_N         4
`define MIS_ST_BUSY      5
`define MIS_ST_SKIP      6
`define MIS_IDX_MAX      8'h5F
`define MIS_ACCESS_SPLIT 8'h60
`define MIS_ACCESS_HIGH  4'hF
`define MIS_OP_LITACC    8'h0E
`define MIS_OP_ACCFILE   7'h37
`define MIS_OP_ADDIDX    6'h09
`define MIS_OP_DECSZ     6'h0B
`define MIS_OP_DECSNZ    6'h13
`define MIS_OP_BSFIDX    4'h8
`define MIS_OP_ONESIDX   8'h68
`define MIS_SKIP_WORDS2  2'h2
`define MIS_SKIP_WORDS1  2'h1
`endif

/* File: verilog/mis_pkg.sv */
// Types shared by the instruction subset executor.
// Assumes mis_map.svh for numeric constants.
package mis_pkg;
	typedef enum logic [2:0]
	{
		MIS_Q1   = 3'b000,
		MIS_Q2   = 3'b001,
		MIS_Q3   = 3'b010,
		MIS_Q4   = 3'b011,
		MIS_IDLE = 3'b100
	} mis_phase_t;
	typedef enum logic [2:0]
	{
		MIS_K_NONE    = 3'b000,
		MIS_K_LITACC  = 3'b001,
		MIS_K_ACCFILE = 3'b010,
		MIS_K_ADDIDX = 3'b011,
		MIS_K_DECSZ  = 3'b100,
		MIS_K_DECSNZ = 3'b101,
		MIS_K_BSFIDX = 3'b110,
		MIS_K_ONESIDX = 3'b111
	} mis_kind_t;
endpackage

/* File: verilog/mis_data_ram.sv */
// Data memory of the executor, one port whose write and registered read share one address.
// Assumes a single clock; read data appears the cycle after the address.
module mis_data_ram #(
	parameter int AW = 12
) (
	// Clock
	input  wire logic          i_ref_clk,
	// Port
	input  wire logic [AW-1:0] i_addr,
	input  wire logic          i_we,
	input  wire logic [7:0]    i_wdata,
	output logic      [7:0]    o_rdata
);
	logic [7:0] mem [0:(1<<AW)-1];
	always_ff @(posedge i_ref_clk)
	begin
		if (i_we)
			mem[i_addr] <= i_wdata;
		o_rdata <= mem[i_addr];
	end
endmodule

/* File: verilog/mis_exec.sv */
// Decode and execute logic for an 8-bit core instruction subset, Wishbone slave.
// Assumes a classic Wishbone master on the same clock and synchronous active low reset.
`include "mis_map.svh"
module mis_exec
	import mis_pkg::*;
#(
	parameter int AW = 12
) (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// Status
	output logic             o_busy
);
	typedef struct packed {
		mis_phase_t  ph;
		mis_kind_t   kind;
		logic [15:0] ins;
		logic [1:0]  skip;
		logic        ext;
		logic        next2w;
		logic [7:0]  acc;
		logic [3:0]  bank;
		logic [11:0] ptr2;
		logic [4:0]  flags;
		logic [AW-1:0] addr;
		logic [7:0]  res;
		logic        we;
		logic        memop;
		logic [31:0] rdat;
		logic        ack;
		logic        busy;
	} mis_state_t;

	mis_state_t s_q;
	mis_state_t s_d;
	logic [7:0] ram_rdata;
	logic [8:0] sum9;
	logic [4:0] nib5;

	// Decode of the 16-bit instruction word into a kind.
	function automatic mis_kind_t decode(input logic [15:0] w);
		mis_kind_t k;
		k = MIS_K_NONE;
		if (w[15:8] == `MIS_OP_LITACC)
			k = MIS_K_LITACC;
		else if (w[15:8] == `MIS_OP_ONESIDX)
			k = MIS_K_ONESIDX;
		else if (w[15:9] == `MIS_OP_ACCFILE)
			k = MIS_K_ACCFILE;
		else if (w[15:10] == `MIS_OP_ADDIDX && !w[8])
			k = MIS_K_ADDIDX;
		else if (w[15:10] == `MIS_OP_DECSZ)
			k = MIS_K_DECSZ;
		else if (w[15:10] == `MIS_OP_DECSNZ)
			k = MIS_K_DECSNZ;
		else if (w[15:12] == `MIS_OP_BSFIDX && !w[8])
			k = MIS_K_BSFIDX;
		return k;
	endfunction

	// Effective data address of a byte-oriented operand.
	function automatic logic [AW-1:0] ea(input logic [15:0] w, input logic ext,
		input logic [3:0] bank, input logic [11:0] p2, input logic idx_only);
		logic [11:0] a;
		a = 12'h000;
		if (idx_only)
			a = p2 + {4'h0, w[7:0]};
		else if (!w[8] && ext && w[7:0] <= `MIS_IDX_MAX)
			a = p2 + {4'h0, w[7:0]};
		else if (!w[8])
			a = (w[7:0] < `MIS_ACCESS_SPLIT) ? {4'h0, w[7:0]}
				: {`MIS_ACCESS_HIGH, w[7:0]};
		else
			a = {bank, w[7:0]};
		return a[AW-1:0];
	endfunction

	assign sum9 = {1'b0, s_q.acc} + {1'b0, ram_rdata};
	assign nib5 = {1'b0, s_q.acc[3:0]} + {1'b0, ram_rdata[3:0]};

	always_comb
	begin
		logic hit;
		logic [7:0] dec;
		hit = i_wb_cyc && i_wb_stb && !s_q.ack;
		dec = ram_rdata - 8'h01;
		s_d = s_q;
		s_d.ack = hit;
		s_d.we = 1'b0;
		s_d.memop = 1'b0;
		// Bus access; instruction, memory address and memory data writes are taken only while no instruction is in flight.
		if (hit)
		begin
			s_d.rdat = 32'h0000_0000;
			if (i_wb_we && i_wb_sel[0])
			begin
				if (i_wb_adr == `MIS_OFF_CTRL)
				begin
					s_d.ext = i_wb_dat[`MIS_CTRL_EXT];
					s_d.next2w = i_wb_dat[`MIS_CTRL_NEXT2W];
				end
				else if (i_wb_adr == `MIS_OFF_INSTR && i_wb_sel[1] && s_q.ph == MIS_IDLE)
				begin
					s_d.ins = i_wb_dat[15:0];
					s_d.ph = MIS_Q1;
				end
				else if (i_wb_adr == `MIS_OFF_ACC)
					s_d.acc = i_wb_dat[7:0];
				else if (i_wb_adr == `MIS_OFF_BANK)
					s_d.bank = i_wb_dat[3:0];
				else if (i_wb_adr == `MIS_OFF_PTR2 && i_wb_sel[1])
					s_d.ptr2 = i_wb_dat[11:0];
				else if (i_wb_adr == `MIS_OFF_MEMADDR && i_wb_sel[1] && s_q.ph == MIS_IDLE)
					s_d.addr = i_wb_dat[AW-1:0];
				else if (i_wb_adr == `MIS_OFF_MEMDATA && s_q.ph == MIS_IDLE)
				begin
					s_d.res = i_wb_dat[7:0];
					s_d.we = 1'b1;
				end
			end
			else if (!i_wb_we)
			begin
				if (i_wb_adr == `MIS_OFF_CTRL)
					s_d.rdat = {30'h0, s_q.next2w, s_q.ext};
				else if (i_wb_adr == `MIS_OFF_INSTR)
					s_d.rdat = {16'h0000, s_q.ins};
				else if (i_wb_adr == `MIS_OFF_ACC)
					s_d.rdat = {24'h000000, s_q.acc};
				else if (i_wb_adr == `MIS_OFF_BANK)
					s_d.rdat = {28'h0000000, s_q.bank};
				else if (i_wb_adr == `MIS_OFF_PTR2)
					s_d.rdat = {20'h00000, s_q.ptr2};
				else if (i_wb_adr == `MIS_OFF_STATUS)
					s_d.rdat = {25'h0, s_q.skip != 2'h0, s_q.ph != MIS_IDLE, s_q.flags};
				else if (i_wb_adr == `MIS_OFF_MEMADDR)
					s_d.rdat = {{(32-AW){1'b0}}, s_q.addr};
				else if (i_wb_adr == `MIS_OFF_MEMDATA)
					s_d.rdat = {24'h000000, ram_rdata};
			end
		end
		// Four-phase instruction cycle; a pending skip replaces the work with no-ops.
		case (s_q.ph)
			MIS_Q1:
			begin
				s_d.kind = (s_q.skip != 2'h0) ? MIS_K_NONE : decode(s_q.ins);
				s_d.addr = ea(s_q.ins, s_q.ext, s_q.bank, s_q.ptr2,
					decode(s_q.ins) == MIS_K_ADDIDX || decode(s_q.ins) == MIS_K_BSFIDX
					|| decode(s_q.ins) == MIS_K_ONESIDX);
				s_d.ph = MIS_Q2;
			end
			MIS_Q2:
				s_d.ph = MIS_Q3;
			MIS_Q3:
			begin
				s_d.ph = MIS_Q4;
				case (s_q.kind)
					MIS_K_ACCFILE:
						s_d.res = s_q.acc;
					MIS_K_ADDIDX:
					begin
						s_d.res = sum9[7:0];
						s_d.flags[`MIS_ST_C] = sum9[8];
						s_d.flags[`MIS_ST_DC] = nib5[4];
						s_d.flags[`MIS_ST_Z] = (sum9[7:0] == 8'h00);
						s_d.flags[`MIS_ST_N] = sum9[7];
						s_d.flags[`MIS_ST_OV] = (s_q.acc[7] == ram_rdata[7])
							&& (sum9[7] != s_q.acc[7]);
					end
					MIS_K_BSFIDX:
						s_d.res = ram_rdata | (8'h01 << s_q.ins[11:9]);
					MIS_K_ONESIDX:
						s_d.res = 8'hFF;
					MIS_K_DECSZ, MIS_K_DECSNZ:
						s_d.res = dec;
					default:
						s_d.res = s_q.res;
				endcase
			end
			MIS_Q4:
			begin
				s_d.ph = MIS_IDLE;
				if (s_q.skip != 2'h0)
					s_d.skip = s_q.skip - 2'h1;
				case (s_q.kind)
					MIS_K_LITACC:
						s_d.acc = s_q.ins[7:0];
					MIS_K_ACCFILE, MIS_K_BSFIDX, MIS_K_ONESIDX:
						s_d.memop = 1'b1;
					MIS_K_ADDIDX, MIS_K_DECSZ, MIS_K_DECSNZ:
						if (s_q.ins[9])
							s_d.memop = 1'b1;
						else
							s_d.acc = s_q.res;
					default:
						s_d.memop = 1'b0;
				endcase
				if ((s_q.kind == MIS_K_DECSZ && s_q.res == 8'h00)
					|| (s_q.kind == MIS_K_DECSNZ && s_q.res != 8'h00))
					s_d.skip = s_q.next2w ? `MIS_SKIP_WORDS2 : `MIS_SKIP_WORDS1;
				if (s_d.skip != 2'h0)
					s_d.ph = MIS_Q1;
			end
			default:
				s_d.ph = s_d.ph;
		endcase
		if (s_q.ph == MIS_Q4 && s_d.memop)
			s_d.we = 1'b1;
		// Busy is registered so the pin comes straight from a flip-flop.
		s_d.busy = (s_d.ph != MIS_IDLE) || s_d.we;
		if (!i_rst_b)
		begin
			s_d = '0;
			s_d.ph = MIS_IDLE;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		s_q <= s_d;
	end

	// Memory write fires on the cycle after the write phase, from registered state.
	mis_data_ram #(
		.AW (AW)
	) u_ram (
		.i_ref_clk (i_ref_clk),
		.i_addr    (s_q.addr),
		.i_we      (s_q.we),
		.i_wdata   (s_q.res),
		.o_rdata   (ram_rdata)
	);

	assign o_wb_dat = s_q.rdat;
	assign o_wb_ack = s_q.ack;
	assign o_busy = s_q.busy;
endmodule

/* File: tb/mis_prog_rom.sv */
// Program memory model: the instruction words the bench issues.
// Assumes the bench picks words by index; nothing changes during a run.
module mis_prog_rom (
	// Instruction words
	output logic [15:0] o_word [9]
);
	timeunit 1ns;
	timeprecision 1ns;
	assign o_word = '{16'h0E5A, 16'h6E10, 16'h6F20, 16'h2E10, 16'h4E10,
		16'h242C, 16'h262C, 16'h8E0A, 16'h682C};
endmodule

/* File: tb/mis_exec_asserts.sv */
// Checker for bus handshake and busy timing of the executor.
// Assumes it is bound onto mis_exec and sees only its ports.
module mis_exec_asserts (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_b,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        o_busy
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	sequence instr_go;
		take && i_wb_we && i_wb_adr == 8'h04 && !o_busy;
	endsequence
	sequence rd_at(logic [7:0] a);
		take && !i_wb_we && i_wb_adr == a;
	endsequence
	ack_next_a: assert property (take |=> o_wb_ack) else $error("ack missing");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	busy_run_a: assert property (instr_go |=> o_busy[*4]) else $error("short run");
	busy_end_a: assert property (instr_go |-> ##[1:14] !o_busy) else $error("run too long");
	unmapped_zero_a: assert property (take && !i_wb_we && i_wb_adr >= 8'h20 |=> o_wb_dat == 0)
		else $error("unmapped read not zero");
	status_rsv_a: assert property (rd_at(8'h14) |=> o_wb_dat[31:7] == 0)
		else $error("status upper bits set");
	acc_width_a: assert property (rd_at(8'h08) |=> o_wb_dat[31:8] == 0)
		else $error("accumulator wider than a byte");
endmodule
bind mis_exec mis_exec_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_busy(o_busy));

/* File: tb/testbench.sv */
// Self-checking bench for the executor over classic Wishbone.
// Assumes a 10 MHz clock and the executor's register map.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, busy;
	logic [7:0]  adr = 0;
	logic [31:0] wdat = 0, rdat, rq;
	logic [15:0] prog [9];
	int          fails = 0, check_count = 0, cycles = 0;
	mis_prog_rom u_rom (.o_word(prog));
	mis_exec dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .o_busy(busy));
	initial forever #50 clk = ~clk;
	task tally_and_finish;
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard: the whole sequence needs a few hundred cycles.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	task chk(input string what, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One classic cycle; returns one edge after ack so stb is low a full cycle.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rq = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task mem_wr(input logic [11:0] a, input logic [7:0] d);
		wb(1, 8'h18, {20'h0, a});
		wb(1, 8'h1C, {24'h0, d});
	endtask
	task mem_chk(input string what, input logic [11:0] a, input logic [7:0] d);
		wb(1, 8'h18, {20'h0, a});
		wb(0, 8'h1C, 32'h0);
		chk(what, {24'h0, d}, rq);
	endtask
	// Issues one instruction and counts the cycles busy stays high.
	task run(input int i, input int exp_n);
		int n;
		n = 1;
		wb(1, 8'h04, {16'h0, prog[i]});
		while (busy !== 1'b0)
		begin
			n++;
			@(posedge clk);
		end
		chk("busy cycles", exp_n, n);
	endtask
	task reg_chk(input string what, input logic [7:0] a, input logic [31:0] d);
		wb(0, a, 32'h0);
		chk(what, d, rq);
	endtask
	// Busy spans four phases per word issued or skipped, plus one cycle when a memory write is pending at the end.
	task test_literal;
		reg_chk("unmapped", 8'h20, 32'h0);
		run(0, 4);
		reg_chk("acc literal", 8'h08, 32'h5A);
		reg_chk("status", 8'h14, 32'h0);
	endtask
	task test_store;
		run(1, 5);
		mem_chk("access store", 12'h010, 8'h5A);
		wb(1, 8'h0C, 32'h3);
		run(2, 5);
		mem_chk("banked store", 12'h320, 8'h5A);
	endtask
	task test_skip;
		mem_wr(12'h010, 8'h01);
		run(3, 8);
		mem_chk("dec to zero", 12'h010, 8'h00);
		wb(1, 8'h00, 32'h2);
		run(4, 12);
		mem_chk("dec nonzero", 12'h010, 8'hFF);
		mem_wr(12'h010, 8'h01);
		run(4, 5);
	endtask
	task test_indexed;
		wb(1, 8'h00, 32'h1);
		wb(1, 8'h10, 32'hA00);
		mem_wr(12'hA2C, 8'hF9);
		wb(1, 8'h08, 32'h17);
		run(5, 4);
		reg_chk("sum to acc", 8'h08, 32'h10);
		reg_chk("carry flags", 8'h14, 32'h3);
		run(6, 5);
		mem_chk("sum to memory", 12'hA2C, 8'h09);
		reg_chk("carry only", 8'h14, 32'h1);
		mem_wr(12'hA0A, 8'h55);
		run(7, 5);
		mem_chk("bit set", 12'hA0A, 8'hD5);
		run(8, 5);
		mem_chk("all ones", 12'hA2C, 8'hFF);
		reg_chk("flags kept", 8'h14, 32'h1);
		run(1, 5);
		mem_chk("indexed store", 12'hA10, 8'h10);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		test_literal();
		test_store();
		test_skip();
		test_indexed();
		tally_and_finish();
	end
endmodule
